// ==== rtl/pud_defs.svh ====
// byte offsets, codes and reset values of the power-up settings command decoder
`ifndef PUD_DEFS_SVH
`define PUD_DEFS_SVH
// ======================================================================
// packet layout
`define PUD_PKT_LAST       6'h3F
`define PUD_IDX_CMD        6'h00
`define PUD_IDX_SUB        6'h01
`define PUD_IDX_ROLE0      6'h04
`define PUD_IDX_LEVEL      6'h0D
`define PUD_IDX_DIR        6'h0F
`define PUD_IDX_CHIP       6'h11
`define PUD_IDX_ACCESS     6'h12
`define PUD_IDX_PWD0       6'h13
`define PUD_IDX_PWD7       6'h1A
// ======================================================================
// byte 17 field positions
`define PUD_BIT_WAKE       4
`define PUD_BIT_INT_HI     3
`define PUD_BIT_INT_LO     1
`define PUD_BIT_HOLD       0
// ======================================================================
// command, status and access codes
`define PUD_CMD_NV_WRITE   8'h60
`define PUD_SUB_CHIP       8'h20
`define PUD_ST_OK          8'h00
`define PUD_ST_BLOCKED     8'hFB
`define PUD_ST_UNKNOWN     8'hF9
`define PUD_ACC_OPEN       8'h00
`define PUD_ACC_PWD        8'h40
`define PUD_ACC_LOCK       8'h80
// ======================================================================
// reset values of the stored settings
`define PUD_RST_LEVEL      8'h00
`define PUD_RST_DIR        8'hFF
`define PUD_RST_PWD        64'h0000_0000_0000_0000
`endif

// ==== rtl/pud_pkg.sv ====
// types shared by the power-up settings command decoder
package pud_pkg;
    // ==================================================================
    // protection of the stored settings
    typedef enum logic [1:0] {
        PUD_ACC_OPEN_E = 2'b00,
        PUD_ACC_PWD_E  = 2'b01,
        PUD_ACC_LOCK_E = 2'b10
    } pud_access_e;
    // receive / answer sequencing
    typedef enum logic [0:0] {
        PUD_ST_RECV = 1'b0,
        PUD_ST_RESP = 1'b1
    } pud_state_e;
    // ==================================================================
    // stored power-up settings
    typedef struct packed {
        logic [8:0][1:0] pin_role;          // 0 gpio, 1 chip select, 2 dedicated
        logic [7:0]      default_level;     // bit n is pin n
        logic [7:0]      default_direction; // bit n is pin n
        logic            wake_enable;
        logic [2:0]      int_count_mode;
        logic            bus_hold;          // 1 keeps the spi bus between transfers
        pud_access_e     access_mode;
        logic [63:0]     password;          // character 0 in bits 7:0
    } pud_settings_s;
endpackage : pud_pkg

// ==== rtl/pud_decoder.sv ====
// decoder of the 64-byte power-up chip settings write command and its answer
//
// Overview of operation
// [R1] every received packet gets exactly one answer
// [R2] byte 0 code selects nonvolatile write
// [R3] byte 1 sub-command selects chip settings layout
// [R4] host zeroes reserved bytes 2,3,27-63
// [R5] bytes 4-12 give roles of pins 0-8
// [R6] byte 13 default levels, byte 14 ignored
// [R7] byte 15 default directions, byte 16 ignored
// [R8] byte 17 bit 4 wake-up, 7-5 ignored
// [R9] byte 17 bits 3-1 interrupt counting mode
// [R10] byte 17 bit 0 keeps or releases bus
// [R11] byte 18 selects protection of settings
// [R12] bytes 19-26 carry new password characters
// [R13] all-zero new password means no change
// [R14] answer byte 0 echoes the command code
// [R15] blocked status on bad password or lock
// [R16] success answers 0x00 then sub-command echo
// [R17] blocked write changes no stored setting
`include "pud_defs.svh"

module pud_decoder (
    input  wire logic                  core_clk,
    input  wire logic                  rst,
    // command byte stream, 64 bytes a packet
    input  wire logic                  cmd_valid,
    input  wire logic [7:0]            cmd_byte,
    output logic                       cmd_ready,
    // password already supplied by the host
    input  wire logic                  pwd_unlocked,
    // answer byte stream, 64 bytes a packet
    output logic                       rsp_valid,
    output logic [7:0]                 rsp_byte,
    output logic                       rsp_last,
    input  wire logic                  rsp_ready,
    // stored settings and commit pulse
    output pud_pkg::pud_settings_s     stored,
    output logic                       settings_written
);
    import pud_pkg::*;

    // ==================================================================
    // state
    pud_state_e    state;               // receiving or answering
    pud_state_e    next_state;
    logic [5:0]    idx;                 // byte position in the packet
    logic [5:0]    next_idx;
    logic [7:0]    cmd_code;            // byte 0 as received
    logic [7:0]    next_cmd_code;
    logic [7:0]    sub_code;            // byte 1 as received
    logic [7:0]    next_sub_code;
    logic [7:0]    status;              // answer byte 1
    logic [7:0]    next_status;
    logic [7:0]    acc_code;            // byte 18 as received
    logic [7:0]    next_acc_code;
    pud_settings_s stage;               // settings gathered before commit
    pud_settings_s next_stage;
    pud_settings_s next_stored;
    logic [7:0]    next_rsp_byte;
    logic          next_written;
    logic          blocked;             // write refused
    logic          is_write;            // packet is the chip settings write

    // handshakes come straight from the state
    assign cmd_ready = (state == PUD_ST_RECV);
    assign rsp_valid = (state == PUD_ST_RESP);
    assign rsp_last  = (state == PUD_ST_RESP) && (idx == `PUD_PKT_LAST);

    // refused when locked, or protected without the right password
    assign blocked  = (stored.access_mode == PUD_ACC_LOCK_E) ||                  // see [R15]
                      ((stored.access_mode == PUD_ACC_PWD_E) && !pwd_unlocked);
    assign is_write = (cmd_code == `PUD_CMD_NV_WRITE) && (sub_code == `PUD_SUB_CHIP); // see [R2] see [R3]

    // ==================================================================
    // next-value logic: capture bytes, commit, then stream the answer
    always_comb begin
        next_state    = state;
        next_idx      = idx;
        next_cmd_code = cmd_code;
        next_sub_code = sub_code;
        next_status   = status;
        next_acc_code = acc_code;
        next_stage    = stage;
        next_stored   = stored;
        next_rsp_byte = rsp_byte;
        next_written  = 1'b0;
        case (state)
            PUD_ST_RECV: begin
                if (cmd_valid) begin
                    // field capture by byte position; reserved bytes are dropped
                    if (idx == `PUD_IDX_CMD) begin
                        next_cmd_code = cmd_byte;                        // see [R2]
                    end else if (idx == `PUD_IDX_SUB) begin
                        next_sub_code = cmd_byte;                        // see [R3]
                    end else if (idx == `PUD_IDX_LEVEL) begin
                        next_stage.default_level = cmd_byte;             // see [R6]
                    end else if (idx == `PUD_IDX_DIR) begin
                        next_stage.default_direction = cmd_byte;         // see [R7]
                    end else if (idx == `PUD_IDX_CHIP) begin
                        // upper three bits are don't care
                        next_stage.wake_enable    = cmd_byte[`PUD_BIT_WAKE];                  // see [R8]
                        next_stage.int_count_mode = cmd_byte[`PUD_BIT_INT_HI:`PUD_BIT_INT_LO]; // see [R9]
                        next_stage.bus_hold       = cmd_byte[`PUD_BIT_HOLD];                  // see [R10]
                    end else if (idx == `PUD_IDX_ACCESS) begin
                        next_acc_code = cmd_byte;                        // see [R11]
                    end
                    // one role byte per pin, low two bits kept
                    for (int i = 0; i < 9; i++) begin
                        if (idx == `PUD_IDX_ROLE0 + 6'(i)) begin
                            next_stage.pin_role[i] = cmd_byte[1:0];      // see [R5]
                        end
                    end
                    // password characters in order, character 0 lowest
                    for (int j = 0; j < 8; j++) begin
                        if (idx == `PUD_IDX_PWD0 + 6'(j)) begin
                            next_stage.password[j*8 +: 8] = cmd_byte;    // see [R12]
                        end
                    end
                    if (idx == `PUD_PKT_LAST) begin
                        // whole packet in: decide and answer, whatever it was
                        next_state    = PUD_ST_RESP;                     // see [R1]
                        next_idx      = 6'h00;
                        next_rsp_byte = cmd_code;                        // see [R14]
                        if (!is_write) begin
                            next_status = `PUD_ST_UNKNOWN;
                        end else if (blocked) begin
                            next_status = `PUD_ST_BLOCKED;               // see [R15] see [R17]
                        end else begin
                            next_status  = `PUD_ST_OK;                   // see [R16]
                            next_written = 1'b1;
                            next_stored.pin_role          = stage.pin_role;
                            next_stored.default_level     = stage.default_level;
                            next_stored.default_direction = stage.default_direction;
                            next_stored.wake_enable       = stage.wake_enable;
                            next_stored.int_count_mode    = stage.int_count_mode;
                            next_stored.bus_hold          = stage.bus_hold;
                            // an unlisted access code leaves protection as it was
                            if (acc_code == `PUD_ACC_OPEN) begin
                                next_stored.access_mode = PUD_ACC_OPEN_E;  // see [R11]
                            end else if (acc_code == `PUD_ACC_PWD) begin
                                next_stored.access_mode = PUD_ACC_PWD_E;
                            end else if (acc_code == `PUD_ACC_LOCK) begin
                                next_stored.access_mode = PUD_ACC_LOCK_E;
                            end
                            // all zero means keep the old password
                            if (stage.password != `PUD_RST_PWD) begin
                                next_stored.password = stage.password;   // see [R13]
                            end
                        end
                    end else begin
                        next_idx = idx + 6'h01;
                    end
                end
            end
            PUD_ST_RESP: begin
                if (rsp_ready) begin
                    if (idx == `PUD_PKT_LAST) begin
                        // answer done, wait for the next packet
                        next_state = PUD_ST_RECV;
                        next_idx   = 6'h00;
                    end else begin
                        next_idx = idx + 6'h01;
                        // byte 1 status, byte 2 sub-command echo on success, rest zero
                        if (idx == `PUD_IDX_CMD) begin
                            next_rsp_byte = status;                      // see [R15] see [R16]
                        end else if ((idx == `PUD_IDX_SUB) && (status == `PUD_ST_OK)) begin
                            next_rsp_byte = sub_code;                    // see [R16]
                        end else begin
                            next_rsp_byte = 8'h00;
                        end
                    end
                end
            end
            default: begin
                next_state = PUD_ST_RECV;
            end
        endcase
    end

    // ==================================================================
    // registers; settings restart from open defaults since no storage is modelled
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            state                    <= PUD_ST_RECV;
            idx                      <= 6'h00;
            cmd_code                 <= 8'h00;
            sub_code                 <= 8'h00;
            status                   <= 8'h00;
            acc_code                 <= 8'h00;
            stage                    <= '0;
            stored                   <= '0;
            stored.default_level     <= `PUD_RST_LEVEL;
            stored.default_direction <= `PUD_RST_DIR;
            stored.password          <= `PUD_RST_PWD;
            rsp_byte                 <= 8'h00;
            settings_written         <= 1'b0;
        end else begin
            state            <= next_state;
            idx              <= next_idx;
            cmd_code         <= next_cmd_code;
            sub_code         <= next_sub_code;
            status           <= next_status;
            acc_code         <= next_acc_code;
            stage            <= next_stage;
            stored           <= next_stored;
            rsp_byte         <= next_rsp_byte;
            settings_written <= next_written;
        end
    end
endmodule : pud_decoder

// ==== tb/pud_chk.sv ====
// port assertions of the power-up settings command decoder
`include "pud_defs.svh"
module pud_chk (
    input wire logic                  core_clk,
    input wire logic                  rst,
    input wire logic                  cmd_ready,
    input wire logic                  rsp_valid,
    input wire logic [7:0]            rsp_byte,
    input wire logic                  rsp_last,
    input wire logic                  rsp_ready,
    input wire pud_pkg::pud_settings_s stored,
    input wire logic                  settings_written
);
    import pud_pkg::*;
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);
    // ==================================================================
    // answer framing
    // first answer byte handed over at once
    sequence s_start;
        $rose(rsp_valid) && rsp_ready;
    endsequence
    property p_busy; rsp_valid |-> !cmd_ready; endproperty
    a_busy: assert property (p_busy) else $error("command byte accepted while answering");
    property p_last; rsp_last |-> rsp_valid; endproperty
    a_last: assert property (p_last) else $error("last flag outside an answer");
    property p_hold; rsp_valid && !rsp_ready |=> rsp_valid && $stable(rsp_byte); endproperty
    a_hold: assert property (p_hold) else $error("answer byte dropped while stalled");
    property p_end; rsp_last && rsp_ready |=> !rsp_valid && cmd_ready; endproperty
    a_end: assert property (p_end) else $error("answer did not end after last byte");
    property p_echo; $rose(rsp_valid) |-> rsp_byte == `PUD_CMD_NV_WRITE; endproperty
    a_echo: assert property (p_echo) else $error("command code not echoed");
    // ==================================================================
    // commit pulse stands with answer byte 0, so the status that follows must agree with it
    property p_commit; s_start |=> (rsp_byte == `PUD_ST_OK) == $past(settings_written); endproperty
    a_commit: assert property (p_commit) else $error("commit pulse disagrees with status");
    property p_sub; s_start ##1 (rsp_byte == `PUD_ST_OK && rsp_ready) |=> rsp_byte == `PUD_SUB_CHIP; endproperty
    a_sub: assert property (p_sub) else $error("sub-command not echoed after success");
    property p_keep; !$rose(rsp_valid) |-> $stable(stored); endproperty
    a_keep: assert property (p_keep) else $error("stored settings changed outside a commit");
    property p_pulse; settings_written |-> $rose(rsp_valid); endproperty
    a_pulse: assert property (p_pulse) else $error("commit pulse at the wrong cycle");
endmodule : pud_chk
bind pud_decoder pud_chk chk_u (.core_clk, .rst, .cmd_ready, .rsp_valid, .rsp_byte, .rsp_last, .rsp_ready,
    .stored, .settings_written);

// ==== tb/pud_host.sv ====
// host side model: sends one 64-byte command and collects the answer
module pud_host (
    input wire logic        core_clk,
    output logic            cmd_valid,
    output logic [7:0]      cmd_byte,
    input wire logic        cmd_ready,
    input wire logic        rsp_valid,
    input wire logic [7:0]  rsp_byte,
    output logic            rsp_ready
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        cmd_valid = 1'b0;
        cmd_byte  = 8'h00;
        rsp_ready = 1'b0;
    end
    // ==================================================================
    // one full exchange; stall toggles ready to slow the answer
    task automatic xfer(input logic [7:0] pkt [64], input bit stall, output logic [7:0] rsp [64]);
        int i;
        bit taken;
        i = 0;
        // ready is sampled mid-cycle, where it is settled, not in the launching time step
        while (i < 64) begin
            cmd_valid <= 1'b1;
            cmd_byte  <= pkt[i];
            @(negedge core_clk);
            taken = (cmd_ready === 1'b1);
            @(posedge core_clk);
            if (taken) i++;
        end
        // released data shows garbage, not the last byte
        cmd_valid <= 1'b0;
        cmd_byte  <= ~pkt[63];
        rsp_ready <= 1'b1;
        i = 0;
        while (i < 64) begin
            @(negedge core_clk);
            if (rsp_valid === 1'b1 && rsp_ready === 1'b1) begin
                rsp[i] = rsp_byte;
                i++;
            end
            @(posedge core_clk);
            rsp_ready <= (i < 64) && (!stall || !rsp_ready);
        end
    endtask : xfer
endmodule : pud_host

// ==== tb/pud_decoder_tb_top.sv ====
// testbench of the power-up settings command decoder
`include "pud_defs.svh"
module pud_decoder_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import pud_pkg::*;
    typedef struct { logic [7:0] acc, chip, pw; logic unl; logic [7:0] st; } pud_row_s;
    logic core_clk, rst, cmd_valid, cmd_ready, pwd_unlocked, rsp_valid, rsp_last, rsp_ready, settings_written;
    logic [7:0]    cmd_byte, rsp_byte;
    pud_settings_s stored, exp;
    int            err_total, check_count;
    // access, chip flags, password seed, unlocked, status
    pud_row_s rows [7] = '{'{8'h00, 8'hE1, 8'h00, 1'b0, 8'h00}, '{8'h40, 8'h05, 8'h31, 1'b0, 8'h00},
        '{8'h00, 8'h12, 8'h00, 1'b0, 8'hFB}, '{8'h00, 8'h13, 8'h00, 1'b1, 8'h00},
        '{8'h40, 8'h06, 8'h00, 1'b0, 8'h00}, '{8'h80, 8'h08, 8'h00, 1'b1, 8'h00},
        '{8'h00, 8'h0E, 8'h00, 1'b1, 8'hFB}};
    pud_decoder dut_u (.core_clk, .rst, .cmd_valid, .cmd_byte, .cmd_ready, .pwd_unlocked, .rsp_valid,
        .rsp_byte, .rsp_last, .rsp_ready, .stored, .settings_written);
    pud_host host_u (.core_clk, .cmd_valid, .cmd_byte, .cmd_ready, .rsp_valid, .rsp_byte, .rsp_ready);
    // ==================================================================
    // helpers
    task automatic chk(input string what, input logic [127:0] e, input logic [127:0] g);
        check_count++;
        if (g !== e) begin
            err_total++;
            $display("ERROR %s expected %h seen %h", what, e, g);
        end
    endtask : chk
    task automatic end_of_test();
        $display("checks %0d errors %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : end_of_test
    // builds a packet, runs it and updates the expected settings on success
    task automatic run(input logic [7:0] sub, acc, chip, pw, input logic unl, input bit stall, input logic [7:0] st);
        logic [7:0] pkt [64];
        logic [7:0] rsp [64];
        pkt = '{default: 8'h00};
        pkt[0] = `PUD_CMD_NV_WRITE;
        pkt[1] = sub;
        for (int k = 0; k < 9; k++) pkt[4+k] = (k == 8) ? 8'h02 : 8'(k % 3);
        pkt[13] = 8'hA5 ^ chip;
        pkt[14] = 8'hFF;
        pkt[15] = 8'h3C ^ pw;
        pkt[16] = 8'hFF;
        pkt[17] = chip;
        pkt[18] = acc;
        for (int k = 0; k < 8; k++) pkt[19+k] = (pw == 8'h00) ? 8'h00 : pw + 8'(k);
        pwd_unlocked <= unl;
        host_u.xfer(pkt, stall, rsp);
        if (st == `PUD_ST_OK) begin
            for (int k = 0; k < 9; k++) exp.pin_role[k] = pkt[4+k][1:0];
            exp.default_level     = pkt[13];
            exp.default_direction = pkt[15];
            {exp.wake_enable, exp.int_count_mode, exp.bus_hold} = chip[4:0];
            if (acc == `PUD_ACC_PWD) exp.access_mode = PUD_ACC_PWD_E;
            if (acc == `PUD_ACC_LOCK) exp.access_mode = PUD_ACC_LOCK_E;
            if (acc == `PUD_ACC_OPEN) exp.access_mode = PUD_ACC_OPEN_E;
            for (int k = 0; k < 8; k++) if (pw != 8'h00) exp.password[8*k +: 8] = pkt[19+k];
            chk("sub echo", 128'(`PUD_SUB_CHIP), 128'(rsp[2]));
        end
        chk("cmd echo", 128'(pkt[0]), 128'(rsp[0]));
        chk("status", 128'(st), 128'(rsp[1]));
        chk("stored", 128'(exp), 128'(stored));
    endtask : run
    // ==================================================================
    // clock, watchdog and main sequence
    initial begin
        core_clk = 1'b0;
        forever #2 core_clk = ~core_clk;
    end
    initial begin
        repeat (20000) @(posedge core_clk);
        err_total++;
        end_of_test();
    end
    initial begin
        rst = 1'b1;
        pwd_unlocked = 1'b0;
        exp = '0;
        exp.default_direction = `PUD_RST_DIR;
        repeat (2) @(posedge core_clk);
        rst <= 1'b0;
        for (int r = 0; r < 7; r++) begin
            run(`PUD_SUB_CHIP, rows[r].acc, rows[r].chip, rows[r].pw, rows[r].unl, r[0], rows[r].st);
            $display("row %0d done", r);
        end
        // reset in mid-run brings back defaults and an open device
        rst <= 1'b1;
        repeat (2) @(posedge core_clk);
        exp = '0;
        exp.default_direction = `PUD_RST_DIR;
        chk("reset stored", 128'(exp), 128'(stored));
        chk("reset ready", 128'(1), 128'(cmd_ready));
        rst <= 1'b0;
        $display("reset test done");
        // unknown sub-command stores nothing, then a good packet right behind it
        run(8'h10, 8'h80, 8'h0F, 8'h00, 1'b1, 1'b1, `PUD_ST_UNKNOWN);
        run(`PUD_SUB_CHIP, 8'h00, 8'h01, 8'h77, 1'b0, 1'b0, `PUD_ST_OK);
        $display("awkward tests done");
        end_of_test();
    end
endmodule : pud_decoder_tb_top
